/* File: inc/dcp_pkg.sv */
// Shared constants, types and helpers of the delay code control port
package dcp_pkg;

  // ----------------------------------------------------------------
  // Delay code and frame layout
  // ----------------------------------------------------------------
  localparam int          CODE_W         = 6;
  localparam int          NUM_CHAN       = 3;
  localparam int          FRAME_BITS     = 16;
  localparam int          BYTE_BITS      = 8;
  localparam int          DIR_POS        = 7;
  localparam int          COLOR_POS      = 0;
  localparam int          CODE_POS       = 0;
  localparam logic        DIR_WRITE      = 1'b0;
  localparam logic        DIR_READ       = 1'b1;
  localparam logic [1:0]  COLOR_RED      = 2'h0;
  localparam logic [1:0]  COLOR_GREEN    = 2'h1;
  localparam logic [1:0]  COLOR_BLUE     = 2'h2;
  localparam logic [1:0]  COLOR_NONE     = 2'h3;
  localparam logic [5:0]  CODE_RESET     = 6'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          STEP_PS        = 800;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          SCLK_PERIOD_NS = 800;
  // Longest half period, rounded down, never below one cycle
  localparam int          SCLK_HALF_CYC  = (SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
                                           (SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // ----------------------------------------------------------------
  // Controller registers on AHB-Lite
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CMD_OFS    = 8'h00;
  localparam logic [7:0]  REG_STAT_OFS   = 8'h04;
  localparam int          CMD_CODE_POS   = 8;
  localparam int          STAT_BUSY_POS  = 0;
  localparam int          STAT_CODE_POS  = 8;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [31:0] CMD_RESET      = 32'h0000_0000;

  typedef enum logic [1:0] {MODE_SLEEP, MODE_ANALOG, MODE_SPI, MODE_TWO_WIRE} dcp_mode_e;

  // Control-type selection; sleep wins over every other pin
  function automatic dcp_mode_e dcp_mode(input logic sleep_n, input logic analog,
                                         input logic choice);
    if (!sleep_n) return MODE_SLEEP;
    if (analog) return MODE_ANALOG;
    return choice ? MODE_SPI : MODE_TWO_WIRE;
  endfunction

  // Adjustable delay above the common propagation delay, in ps
  function automatic logic [15:0] dcp_code_ps(input logic [CODE_W-1:0] code);
    return 16'(32'(code) * STEP_PS);
  endfunction

endpackage

/* File: inc/dcp_spi_if.sv */
// Four-wire serial link between the controller and the delay device
`timescale 1ns/1ps
interface dcp_spi_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic serial_out;

  modport dev  (input sclk, input cs_n, input serial_in, output serial_out);
  modport host (output sclk, output cs_n, output serial_in, input serial_out);
endinterface

/* File: rtl/dcp_device.sv */
// Delay device logic: mode select, three delay codes, serial slave port
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module dcp_device
  import dcp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                       CLK_SYS,
  input  wire logic                       NRST,
  input  wire logic                       CE,
  // Control-selection pins
  input  wire logic                       SLEEP_N,
  input  wire logic                       CTRL_ANALOG,
  input  wire logic                       SERIAL_PORT_CHOICE,
  // Quantised control voltages from the converter
  input  wire logic [dcp_pkg::CODE_W-1:0] RED_CTRL_VOLTAGE,
  input  wire logic [dcp_pkg::CODE_W-1:0] GREEN_CTRL_VOLTAGE,
  input  wire logic [dcp_pkg::CODE_W-1:0] BLUE_CTRL_VOLTAGE,
  // Mode status
  output logic                            POWERED_DOWN,
  output logic                            ANALOG_ACTIVE,
  output logic                            SPI_ACTIVE,
  output logic                            TWO_WIRE_ACTIVE,
  // Delay codes and adjustable delays applied to the delay paths
  output logic      [dcp_pkg::CODE_W-1:0] RED_DELAY_CODE,
  output logic      [dcp_pkg::CODE_W-1:0] GREEN_DELAY_CODE,
  output logic      [dcp_pkg::CODE_W-1:0] BLUE_DELAY_CODE,
  output logic      [15:0]                RED_DELAY_PS,
  output logic      [15:0]                GREEN_DELAY_PS,
  output logic      [15:0]                BLUE_DELAY_PS,
  // Serial link
  dcp_spi_if.dev                          LINK
);
  import dcp_pkg::*;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0]        pins_s;
  logic [2:0]        link_s;
  logic [CODE_W-1:0] adc_s [0:2];
  logic              sclk_d_ff;

  // Pins and link both come from outside the system clock
  dcp_sync #(.W(3)) u_pin_sync (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .CE      (CE),
    .D       ({SLEEP_N, CTRL_ANALOG, SERIAL_PORT_CHOICE}),
    .Q       (pins_s)
  );

  dcp_sync #(.W(3)) u_link_sync (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .CE      (CE),
    .D       ({LINK.sclk, LINK.cs_n, LINK.serial_in}),
    .Q       (link_s)
  );

  dcp_sync #(.W(3 * CODE_W)) u_adc_sync (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .CE      (CE),
    .D       ({RED_CTRL_VOLTAGE, GREEN_CTRL_VOLTAGE, BLUE_CTRL_VOLTAGE}),
    .Q       ({adc_s[0], adc_s[1], adc_s[2]})
  );

  logic sclk_s;
  logic cs_n_s;
  logic ser_in_s;
  logic sclk_rise;

  assign sclk_s   = link_s[2];
  assign cs_n_s   = link_s[1];
  assign ser_in_s = link_s[0];

  // Edge found against a third flop, never the first stage
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      sclk_d_ff <= 1'b0;
    end else if (CE) begin
      sclk_d_ff <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s && !sclk_d_ff;

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  dcp_mode_e mode;
  logic      spi_on;

  assign mode   = dcp_mode(pins_s[2], pins_s[1], pins_s[0]);
  assign spi_on = (mode == MODE_SPI);

  // Mode flags registered so each output comes from a flop
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      POWERED_DOWN    <= 1'b1;
      ANALOG_ACTIVE   <= 1'b0;
      SPI_ACTIVE      <= 1'b0;
      TWO_WIRE_ACTIVE <= 1'b0;
    end else if (CE) begin
      POWERED_DOWN    <= (mode == MODE_SLEEP);
      ANALOG_ACTIVE   <= (mode == MODE_ANALOG);
      SPI_ACTIVE      <= (mode == MODE_SPI);
      TWO_WIRE_ACTIVE <= (mode == MODE_TWO_WIRE);
    end
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  logic [3:0]          cnt_ff;
  logic [BYTE_BITS-2:0] shift_ff;
  logic [BYTE_BITS-1:0] cmd_ff;
  logic [BYTE_BITS-1:0] rd_byte_ff;
  logic                ser_out_ff;
  logic [CODE_W-1:0]   code_ff [0:2];
  logic [BYTE_BITS-1:0] cur_byte;
  logic                bit_take;
  logic                frame_done;
  logic [2:0]          out_idx;

  // Stored code of a color, zeros for the unassigned select
  function automatic logic [CODE_W-1:0] stored_code(input logic [1:0] sel);
    unique case (sel)
      COLOR_RED:   return code_ff[0];
      COLOR_GREEN: return code_ff[1];
      COLOR_BLUE:  return code_ff[2];
      default:     return CODE_RESET;
    endcase
  endfunction

  // only while chip select low and the serial port chosen
  assign bit_take   = spi_on && !cs_n_s && sclk_rise;
  // MSB first into the byte under assembly
  assign cur_byte   = {shift_ff, ser_in_s};
  // sixteenth bit closes the two-byte frame
  assign frame_done = bit_take && (cnt_ff == 4'(FRAME_BITS - 1));
  assign out_idx    = 3'(4'hE - cnt_ff);

  // Bit counter and input shifter; chip select high restarts the frame
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cnt_ff   <= 4'h0;
      shift_ff <= '0;
    end else if (CE) begin
      if (!spi_on || cs_n_s) begin
        cnt_ff <= 4'h0;
      end else if (bit_take) begin
        cnt_ff   <= cnt_ff + 4'h1;
        shift_ff <= cur_byte[BYTE_BITS-2:0];
      end
    end
  end

  // Command byte latch and read byte capture at the eighth bit
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cmd_ff     <= '0;
      rd_byte_ff <= '0;
    end else if (CE && bit_take && cnt_ff == 4'(BYTE_BITS - 1)) begin
      // direction bit 7, color bits 1:0
      cmd_ff     <= cur_byte;
      rd_byte_ff <= {2'b00, stored_code(cur_byte[COLOR_POS +: 2])};
    end
  end

  // Output bit for the next position, updated on each rising edge
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ser_out_ff <= 1'b0;
    end else if (CE) begin
      if (!spi_on || cs_n_s) begin
        ser_out_ff <= 1'b0;
      end else if (bit_take) begin
        // read code shifts out in the data byte
        // output runs while input is taken
        if (cmd_ff[DIR_POS] == DIR_READ && cnt_ff >= 4'(BYTE_BITS)
            && cnt_ff < 4'(FRAME_BITS - 1)) begin
          ser_out_ff <= rd_byte_ff[out_idx];
        end else begin
          ser_out_ff <= 1'b0;
        end
      end
    end
  end
  assign LINK.serial_out = ser_out_ff;

  // Stored codes change only at a complete write frame
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        code_ff[i] <= CODE_RESET;
      end
    end else if (CE && frame_done && cmd_ff[DIR_POS] == DIR_WRITE) begin
      unique case (cmd_ff[COLOR_POS +: 2])
        COLOR_RED:   code_ff[0] <= cur_byte[CODE_POS +: CODE_W];
        COLOR_GREEN: code_ff[1] <= cur_byte[CODE_POS +: CODE_W];
        COLOR_BLUE:  code_ff[2] <= cur_byte[CODE_POS +: CODE_W];
        default:     ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Codes applied to the delay paths
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] act [0:2];

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      act[i] = (mode == MODE_ANALOG) ? adc_s[i] : code_ff[i];
    end
  end

  // Codes and delays held in flops; a sleeping part keeps its last setting
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      RED_DELAY_CODE   <= CODE_RESET;
      GREEN_DELAY_CODE <= CODE_RESET;
      BLUE_DELAY_CODE  <= CODE_RESET;
      RED_DELAY_PS     <= 16'h0000;
      GREEN_DELAY_PS   <= 16'h0000;
      BLUE_DELAY_PS    <= 16'h0000;
    end else if (CE && mode != MODE_SLEEP) begin
      RED_DELAY_CODE   <= act[0];
      GREEN_DELAY_CODE <= act[1];
      BLUE_DELAY_CODE  <= act[2];
      RED_DELAY_PS     <= dcp_code_ps(act[0]);
      GREEN_DELAY_PS   <= dcp_code_ps(act[1]);
      BLUE_DELAY_PS    <= dcp_code_ps(act[2]);
    end
  end
endmodule

/* File: rtl/dcp_host.sv */
// Serial bus master with AHB-Lite command and status registers
`timescale 1ns/1ps
module dcp_host
  import dcp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        CE,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Serial link
  dcp_spi_if.host          LINK
);
  import dcp_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_TAIL} dcp_hst_e;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        wr_pend_ff;
  logic [7:0]  wr_ofs_ff;
  logic [31:0] cmd_ff;
  logic        start_ff;
  logic        busy_ff;
  logic [5:0]  rdata_ff;
  logic        addr_ok;

  assign addr_ok = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HSIZE == 3'h2;

  // Zero wait states; read data prepared during the address phase
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 8'h00;
      HRDATA     <= 32'h0000_0000;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
    end else if (CE) begin
      wr_pend_ff <= addr_ok && HWRITE;
      wr_ofs_ff  <= HADDR[7:0];
      HRDATA     <= 32'h0000_0000;
      if (addr_ok && !HWRITE) begin
        if (HADDR[7:0] == REG_CMD_OFS) begin
          HRDATA <= cmd_ff;
        end else if (HADDR[7:0] == REG_STAT_OFS) begin
          HRDATA <= {16'h0000, 2'b00, rdata_ff, 7'h00, busy_ff};
        end
      end
    end
  end

  // Command write starts a frame; ignored while one is running
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cmd_ff   <= CMD_RESET;
      start_ff <= 1'b0;
    end else if (CE) begin
      start_ff <= 1'b0;
      if (wr_pend_ff && wr_ofs_ff == REG_CMD_OFS && !busy_ff && !start_ff) begin
        cmd_ff   <= HWDATA;
        start_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  dcp_hst_e  st_ff;
  logic [7:0] half_ff;
  logic [4:0] bit_ff;
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  logic        sclk_ff;
  logic        cs_n_ff;
  logic        ser_in_ff;
  logic        ser_out_s;
  logic        half_end;

  dcp_sync #(.W(1)) u_sdo_sync (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .CE      (CE),
    .D       (LINK.serial_out),
    .Q       (ser_out_s)
  );

  assign half_end = (half_ff == 8'(SCLK_HALF_CYC - 1));

  // Clock made by dividing the system clock; bits change at low phase
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      st_ff   <= ST_IDLE;
      half_ff <= 8'h00;
      bit_ff  <= 5'h00;
      tx_ff   <= 16'h0000;
      rx_ff   <= 16'h0000;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      ser_in_ff <= 1'b0;
      busy_ff <= 1'b0;
      rdata_ff <= 6'h00;
    end else if (CE) begin
      half_ff <= half_end ? 8'h00 : half_ff + 8'h01;
      unique case (st_ff)
        ST_IDLE: begin
          half_ff <= 8'h00;
          if (start_ff) begin
            tx_ff   <= {cmd_ff[DIR_POS], 5'b00000, cmd_ff[COLOR_POS +: 2],
                        2'b00, cmd_ff[CMD_CODE_POS +: CODE_W]};
            busy_ff <= 1'b1;
            cs_n_ff <= 1'b0;
            bit_ff  <= 5'h00;
            st_ff   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          ser_in_ff <= tx_ff[15];
          if (half_end) st_ff <= ST_LOW;
        end
        ST_LOW: begin
          if (half_end) begin
            sclk_ff <= 1'b1;
            rx_ff   <= {rx_ff[14:0], ser_out_s};
            bit_ff  <= bit_ff + 5'h01;
            tx_ff   <= {tx_ff[14:0], 1'b0};
            st_ff   <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_end) begin
            sclk_ff <= 1'b0;
            ser_in_ff <= tx_ff[15];
            st_ff   <= (bit_ff == 5'(FRAME_BITS)) ? ST_TAIL : ST_LOW;
          end
        end
        ST_TAIL: begin
          if (half_end) begin
            cs_n_ff  <= 1'b1;
            busy_ff  <= 1'b0;
            rdata_ff <= rx_ff[CODE_POS +: CODE_W];
            st_ff    <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign LINK.sclk      = sclk_ff;
  assign LINK.cs_n      = cs_n_ff;
  assign LINK.serial_in = ser_in_ff;
endmodule

/* File: rtl/dcp_sync.sv */
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module dcp_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input  wire logic         CLK_SYS,
  input  wire logic         NRST,
  input  wire logic         CE,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      meta_ff <= '0;
      Q       <= '0;
    end else if (CE) begin
      meta_ff <= D;
      Q       <= meta_ff;
    end
  end
endmodule

/* File: test/dcp_link_assertions.sv */
// Wire-level checks of the four-wire link between host and device
`timescale 1ns/1ps
module dcp_link_assertions (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic serial_out
);
  logic       sclk_q_ff;
  logic [4:0] rises_ff;

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Previous link clock, to spot its rising edges
  always_ff @(posedge CLK_SYS) begin
    sclk_q_ff <= NRST ? sclk : 1'b0;
  end

  // Rising edges seen so far in this frame; cleared while deselected
  always_ff @(posedge CLK_SYS) begin
    if (!NRST || cs_n) begin
      rises_ff <= 5'h00;
    end else if (sclk && !sclk_q_ff) begin
      rises_ff <= rises_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("link clock moved outside a frame");
  cs_setup_a: assert property ($fell(cs_n) |-> !sclk [*3])
    else $error("link clock rose too soon after select");
  high_half_a: assert property ($rose(sclk) |-> sclk [*4])
    else $error("link clock high half too short");
  low_half_a: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("link clock low half too short");
  data_hold_a: assert property ($rose(sclk) |=> $stable(serial_in) [*3])
    else $error("serial input moved while clock high");
  frame_len_a: assert property ($rose(cs_n) |-> rises_ff == 5'h10)
    else $error("frame did not carry sixteen bits");
  cmd_zero_a: assert property ((sclk && !sclk_q_ff && rises_ff >= 5'h01 &&
                                rises_ff <= 5'h05) |-> !serial_in)
    else $error("command padding bit not zero");
  frame_span_a: assert property ($fell(cs_n) |-> ##[128:180] $rose(cs_n))
    else $error("frame length out of range");
  // Device output settles low once the deselect has passed its synchroniser
  out_idle_a: assert property (cs_n [*4] |-> !serial_out)
    else $error("serial output not low while deselected");
endmodule

/* File: test/delay_code_control_port_test.sv */
// Self-checking bench: host and device joined over the four-wire link
`timescale 1ns/1ps
module delay_code_control_port_test;
  import dcp_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk     = 1'b0;
  logic        nrst    = 1'b0;
  logic        host_nrst = 1'b0;
  logic        sleep_n = 1'b1;
  logic        analog  = 1'b0;
  logic        choice  = 1'b1;
  logic [5:0]  volt   [3] = '{6'h00, 6'h00, 6'h00};
  logic [5:0]  stored [3] = '{6'h00, 6'h00, 6'h00};
  logic [5:0]  old    [3];
  logic [5:0]  code   [3];
  logic [15:0] ps     [3];
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic [3:0]  flags;
  int          mismatches = 0;
  int          tests_run  = 0;
  dcp_spi_if   link ();

  // Clock at 10 MHz
  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Design and checker
  // ----------------------------------------------------------------
  dcp_device u_dcp_device (
    .CLK_SYS(clk), .NRST(nrst), .CE(1'b1), .SLEEP_N(sleep_n), .CTRL_ANALOG(analog),
    .SERIAL_PORT_CHOICE(choice), .RED_CTRL_VOLTAGE(volt[0]),
    .GREEN_CTRL_VOLTAGE(volt[1]), .BLUE_CTRL_VOLTAGE(volt[2]),
    .POWERED_DOWN(flags[3]), .ANALOG_ACTIVE(flags[2]), .SPI_ACTIVE(flags[1]),
    .TWO_WIRE_ACTIVE(flags[0]), .RED_DELAY_CODE(code[0]), .GREEN_DELAY_CODE(code[1]),
    .BLUE_DELAY_CODE(code[2]), .RED_DELAY_PS(ps[0]), .GREEN_DELAY_PS(ps[1]),
    .BLUE_DELAY_PS(ps[2]), .LINK(link));
  dcp_host u_dcp_host (
    .CLK_SYS(clk), .NRST(host_nrst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(), .LINK(link));
  dcp_link_assertions chk (
    .CLK_SYS(clk), .NRST(host_nrst), .sclk(link.sclk), .cs_n(link.cs_n),
    .serial_in(link.serial_in), .serial_out(link.serial_out));

  // ----------------------------------------------------------------
  // Expectations and comparisons
  // ----------------------------------------------------------------
  function automatic logic [3:0] want_flags(input logic s, input logic a, input logic c);
    if (!s) return 4'h8;
    if (a) return 4'h4;
    return c ? 4'h2 : 4'h1;
  endfunction

  function automatic logic [15:0] want_ps(input logic [5:0] c);
    return 16'(c) * 16'h0320;
  endfunction

  task automatic chk_code(input string what, input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_ps(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t delay got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t mode flags got %h want %h", $time, got, exp);
    end
  endtask

  // All three applied codes and their delays
  task automatic chk_chan(input logic [5:0] e [3]);
    for (int i = 0; i < 3; i++) begin
      chk_code("applied code", code[i], e[i]);
      chk_ps(ps[i], want_ps(e[i]));
    end
  endtask

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Single word transfer; address held until hready, then data phase
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= addr;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // One link frame through the host, waiting on its busy flag
  task automatic spi_op(input logic dir, input logic [1:0] col, input logic [5:0] val,
                        output logic [5:0] got);
    logic [31:0] r;
    ahb(1'b1, {24'h0, REG_CMD_OFS}, {18'h0, val, dir, 5'h00, col}, r);
    // Busy only shows one edge after the start is taken
    repeat (3) @(posedge clk);
    do ahb(1'b0, {24'h0, REG_STAT_OFS}, 32'h0, r); while (r[0] !== 1'b0);
    got = r[13:8];
    repeat (2) @(posedge clk);
  endtask

  // Pins change after an edge; flags settle through the synchronisers
  task automatic set_mode(input logic s, input logic a, input logic c);
    @(posedge clk);
    sleep_n <= s;
    analog  <= a;
    choice  <= c;
    repeat (6) @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [5:0] got;
    logic [5:0] val;
    logic [31:0] rd;
    void'($urandom(61));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    host_nrst <= 1'b1;
    // Every pin combination of the mode table
    for (int i = 0; i < 8; i++) begin
      set_mode(i[2], i[1], i[0]);
      chk_flags(flags, want_flags(i[2], i[1], i[0]));
    end
    $display("test modes done");
    // Writes with full-scale and random codes, each read back at once
    set_mode(1'b1, 1'b0, 1'b1);
    for (int n = 0; n < 9; n++) begin
      val = (n < 3) ? 6'h3F : 6'($urandom);
      spi_op(DIR_WRITE, 2'(n % 3), val, got);
      stored[n % 3] = val;
      chk_chan(stored);
      spi_op(DIR_READ, 2'(n % 3), 6'($urandom), got);
      chk_code("read back", got, stored[n % 3]);
      chk_chan(stored);
    end
    $display("test write read done");
    // Unassigned color value
    spi_op(DIR_WRITE, COLOR_NONE, 6'($urandom), got);
    chk_chan(stored);
    spi_op(DIR_READ, COLOR_NONE, 6'h15, got);
    chk_code("no color read", got, 6'h00);
    $display("test no color done");
    // Host reset lifts chip select inside the data byte of a write
    ahb(1'b1, {24'h0, REG_CMD_OFS}, {18'h0, ~stored[1], DIR_WRITE, 5'h00, COLOR_GREEN}, rd);
    repeat (100) @(posedge clk);
    host_nrst <= 1'b0;
    repeat (4) @(posedge clk);
    host_nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk_chan(stored);
    $display("test cut frame done");
    // Frame sent while the two-wire port is chosen is ignored
    set_mode(1'b1, 1'b0, 1'b0);
    spi_op(DIR_WRITE, COLOR_RED, ~stored[0], got);
    set_mode(1'b1, 1'b0, 1'b1);
    chk_chan(stored);
    $display("test port choice done");
    // Analog codes, frozen in sleep, then serial codes again
    @(posedge clk);
    foreach (volt[i]) volt[i] <= 6'($urandom);
    set_mode(1'b1, 1'b1, 1'b0);
    chk_chan(volt);
    old = volt;
    set_mode(1'b0, 1'b1, 1'b0);
    foreach (volt[i]) volt[i] <= ~old[i];
    repeat (6) @(posedge clk);
    chk_chan(old);
    set_mode(1'b1, 1'b0, 1'b1);
    chk_chan(stored);
    $display("test analog done");
    summarize();
  end

  // Watchdog well beyond the expected run of some 3300 cycles
  initial begin
    #(30_000 * 100);
    mismatches++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
endmodule
